// ### hw/sspx_exec.sv
// Execute block: fill-ones, sleep entry and pointer literal subtract
// Functional notes
// - Fill-ones op 0110100a writes FFh to addressed register, flags kept.
// - Bank bit 0 selects access bank; 1 uses bank select register.
// - Bank 0 with extended set and address <= 95 uses indexed offset.
// - Word 0003h decodes as sleep entry.
// - Sleep clears the power-down flag.
// - Sleep sets the time-out flag.
// - Sleep clears watchdog counter and its postscaler.
// - Sleep halts oscillator in Q4 after a no-op Q2.
// - Windowed watchdog wake-up clears the time-out flag.
// - Pointer subtract: upper byte E9h, bits 7:6 pointer, 5:0 literal.
// - Subtract unsigned 6-bit literal from pointer 0, 1 or 2.
// - Pointer subtract keeps flags, writes back in Q4.
`timescale 1ns/10ps
module sspx_exec
  import sspx_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int BANK_W = 6
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic wake_req,
  input wire logic windowed_watchdog_wake,
  output logic [3:0] qphase,
  output logic fill_we,
  output logic [BANK_W+7:0] fill_addr,
  output logic [7:0] fill_data,
  output logic fill_indexed,
  output logic power_down_flag,
  output logic timeout_flag,
  output logic watchdog_clr,
  output logic osc_stop,
  output logic [PTR_W-1:0] indirect_pointer0,
  output logic [PTR_W-1:0] indirect_pointer1,
  output logic [PTR_W-1:0] indirect_pointer2
);
  // All-ones decodes as none of the three words, so it acts as a NOP
  localparam logic [15:0] NOP_WORD = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  sspx_q_e q_q;
  sspx_q_e q_d;
  logic [15:0] ir_q;
  logic wake_s1_q;
  logic wake_s2_q;
  logic wwd_s1_q;
  logic wwd_s2_q;

  logic [PTR_W-1:0] ptr_q [3];
  sspx_dec_if dec_bus();

  sspx_decode u_dec (.word(ir_q), .d(dec_bus));

  ////////////////////////////////////////////////////////////////////////////
  // Execute strobes are true in Q3, so each effect shows during Q4, except the pointer outputs, which follow in Q1
  logic exec_fill;
  logic exec_sleep;
  logic exec_psub;
  logic take_word;
  logic wake_any;
  assign exec_fill = (q_q == SSPX_Q3) && dec_bus.is_fill;
  assign exec_sleep = (q_q == SSPX_Q3) && dec_bus.is_sleep;
  assign exec_psub = (q_q == SSPX_Q3) && dec_bus.is_psub;
  // No word is taken while the oscillator is held
  assign take_word = (q_q == SSPX_Q4) && !osc_stop;
  assign wake_any = wake_s2_q || wwd_s2_q;

  // Wraps modulo 2^PTR_W; no borrow is kept since no flag records it
  function automatic logic [PTR_W-1:0] ptr_sub(input logic [PTR_W-1:0] p,
                                               input logic [5:0] k);
    ptr_sub = p - PTR_W'(k);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-cycle sequencer; stalls in Q4 while sleeping
  always_comb begin
    case (q_q)
      SSPX_Q1: q_d = SSPX_Q2;
      SSPX_Q2: q_d = SSPX_Q3;
      SSPX_Q3: q_d = SSPX_Q4;
      SSPX_Q4: q_d = osc_stop ? SSPX_Q4 : SSPX_Q1;
      default: q_d = SSPX_Q1;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q_q <= SSPX_Q1;
    end else begin
      q_q <= q_d;
    end
  end

  // Copy of the sequencer as its own flop, so the port needs no decode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      qphase <= SSPX_Q1;
    end else begin
      qphase <= q_d;
    end
  end

  // Instruction latched in Q4 so Q1 decodes a stable word; NOP otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ir_q <= NOP_WORD;
    end else if (take_word) begin
      ir_q <= instr_valid ? instr_word : NOP_WORD;
    end
  end

  // Wake inputs come from other domains
  // Only the second stage is read; the first may still be settling
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wwd_s1_q <= 1'b0;
      wwd_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_req;
      wake_s2_q <= wake_s1_q;
      wwd_s1_q <= windowed_watchdog_wake;
      wwd_s2_q <= wwd_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fill-ones write, issued in Q4
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fill_we <= 1'b0;
      fill_addr <= '0;
      fill_data <= 8'h00;
      fill_indexed <= 1'b0;
    end else begin
      fill_we <= exec_fill;
      // Data is constant but driven, so the write port stays generic
      if (exec_fill) begin
        fill_data <= SSPX_ONES;
        if (dec_bus.bank_bit) begin
          fill_addr <= {bank_select_reg, dec_bus.faddr};
          fill_indexed <= 1'b0;
        end else begin
          // Access bank: bank field zero; indexed leaves the offset to caller
          fill_addr <= {{BANK_W{1'b0}}, dec_bus.faddr};
          fill_indexed <= ext_set_en &&
            (dec_bus.faddr <= SSPX_IDX_MAX);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep: Q2 does nothing, Q4 stops the oscillator
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_stop <= 1'b0;
    end else if (osc_stop && wake_any) begin
      // Wake first, so a pending wake is never lost behind a sleep
      osc_stop <= 1'b0;
    end else if (exec_sleep) begin
      osc_stop <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_clr <= 1'b0;
    end else begin
      watchdog_clr <= exec_sleep;
    end
  end

  // Flags are active-low style status bits; reset shows power-on values
  // A windowed wake clears only while asleep; the sequencer is parked in
  // Q4 then, so it can never meet a sleep entry in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end else if (exec_sleep) begin
      power_down_flag <= 1'b0;
      timeout_flag <= 1'b1;
    end else if (osc_stop && wwd_s2_q) begin
      timeout_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer subtract, written back in Q4, no flag touched
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ptr_q[0] <= '0;
      ptr_q[1] <= '0;
      ptr_q[2] <= '0;
    end else if (exec_psub) begin
      // Select 3 never gets here: the decoder treats it as a NOP
      ptr_q[dec_bus.ptr_sel] <= ptr_sub(ptr_q[dec_bus.ptr_sel],
                                        dec_bus.literal);
    end
  end

  // Pointer outputs trail the internal copy by one edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      indirect_pointer0 <= '0;
      indirect_pointer1 <= '0;
      indirect_pointer2 <= '0;
    end else begin
      indirect_pointer0 <= ptr_q[0];
      indirect_pointer1 <= ptr_q[1];
      indirect_pointer2 <= ptr_q[2];
    end
  end
endmodule

// ### inc/sspx_pkg.sv
// Shared constants and types for the three-instruction execute block
package sspx_pkg;
  localparam int unsigned SSPX_CLK_HZ = 10_000_000;
  localparam logic [15:0] SSPX_SLEEP_WORD = 16'h0003;
  localparam logic [6:0] SSPX_FILL_OPC = 7'h34;
  localparam logic [7:0] SSPX_PSUB_OPC = 8'hE9;
  localparam logic [7:0] SSPX_ONES = 8'hFF;
  localparam logic [7:0] SSPX_IDX_MAX = 8'h5F;
  localparam logic [1:0] SSPX_PTR_MAX = 2'h2;
  localparam int SSPX_OPC7_HI = 15;
  localparam int SSPX_OPC7_LO = 9;
  localparam int SSPX_BANK_BIT = 8;
  localparam int SSPX_SEL_HI = 7;
  localparam int SSPX_SEL_LO = 6;
  localparam int SSPX_LIT_HI = 5;

  typedef enum logic [3:0] {
    SSPX_Q1 = 4'h1,
    SSPX_Q2 = 4'h2,
    SSPX_Q3 = 4'h4,
    SSPX_Q4 = 4'h8
  } sspx_q_e;
endpackage

// ### inc/sspx_dec_if.sv
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/10ps
interface sspx_dec_if;
  logic is_fill;
  logic is_sleep;
  logic is_psub;
  logic bank_bit;
  logic [7:0] faddr;
  logic [1:0] ptr_sel;
  logic [5:0] literal;
  modport dec (output is_fill, is_sleep, is_psub, bank_bit, faddr, ptr_sel,
    literal);
  modport exe (input is_fill, is_sleep, is_psub, bank_bit, faddr, ptr_sel,
    literal);
endinterface

// ### hw/sspx_decode.sv
// Combinational decoder for the three instruction words
`timescale 1ns/10ps
module sspx_decode
  import sspx_pkg::*;
(
  input wire logic [15:0] word,
  sspx_dec_if.dec d
);
  always_comb begin
    d.is_fill = (word[SSPX_OPC7_HI:SSPX_OPC7_LO] == SSPX_FILL_OPC);
    d.is_sleep = (word == SSPX_SLEEP_WORD);
    d.is_psub = (word[15:8] == SSPX_PSUB_OPC) &&
      (word[SSPX_SEL_HI:SSPX_SEL_LO] <= SSPX_PTR_MAX);
    d.bank_bit = word[SSPX_BANK_BIT];
    d.faddr = word[7:0];
    d.ptr_sel = word[SSPX_SEL_HI:SSPX_SEL_LO];
    d.literal = word[SSPX_LIT_HI:0];
  end
endmodule

// ### test/sspx_exec_sva.sv
// Port assertions for the execute block
`timescale 1ns/10ps
module sspx_exec_sva
  import sspx_pkg::*;
#(parameter int PTR_W = 16, parameter int BANK_W = 6)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [BANK_W-1:0] bank_select_reg,
  input wire logic [3:0] qphase,
  input wire logic fill_we,
  input wire logic [BANK_W+7:0] fill_addr,
  input wire logic fill_indexed,
  input wire logic power_down_flag,
  input wire logic timeout_flag,
  input wire logic watchdog_clr,
  input wire logic osc_stop,
  input wire logic [PTR_W-1:0] indirect_pointer0
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // A word counts only when taken at Q4 with the oscillator running
  wire take = qphase == SSPX_Q4 && !osc_stop && instr_valid;
  wire fill = take && instr_word[15:9] == SSPX_FILL_OPC;
  wire slp = take && instr_word == SSPX_SLEEP_WORD;
  wire sub0 = take && instr_word[15:6] == {SSPX_PSUB_OPC, 2'h0};
  fill_ones_a: assert property (fill |-> ##4 fill_we)
    else $error("fill write missing");
  fill_bank_a: assert property (fill_we |-> fill_addr ==
    {bank_select_reg & {BANK_W{$past(instr_word[8], 4)}},
    $past(instr_word[7:0], 4)}) else $error("fill address wrong");
  fill_idx_a: assert property (fill_we |-> fill_indexed ==
    (!$past(instr_word[8], 4) && ext_set_en &&
    $past(instr_word[7:0], 4) <= SSPX_IDX_MAX)) else $error("index wrong");
  sleep_pd_a: assert property (slp |-> ##4 !power_down_flag)
    else $error("power-down flag kept");
  sleep_to_a: assert property (slp |-> ##4 timeout_flag)
    else $error("timeout flag not set");
  wdt_clr_a: assert property (
    slp |-> ##4 watchdog_clr ##1 !watchdog_clr) else $error("bad clear");
  osc_stop_a: assert property (slp |-> ##3 !osc_stop ##1 osc_stop)
    else $error("oscillator not stopped in Q4");
  ptr_sub_a: assert property (sub0 |-> ##5 indirect_pointer0 ==
    $past(indirect_pointer0) - $past(instr_word[5:0], 5))
    else $error("pointer subtract wrong");
  cover property (fill_we && fill_indexed);
  cover property (slp ##4 osc_stop);
  cover property (sub0);
endmodule
bind sspx_exec sspx_exec_sva #(.PTR_W(PTR_W), .BANK_W(BANK_W)) u_sva (.*);

// ### test/sspx_exec_tb_top.sv
// Self-checking bench for the execute block
`timescale 1ns/10ps
module sspx_exec_tb_top
  import sspx_pkg::*;
;
  logic mclk = 1'h0, rstn = 1'h0, instr_valid = 1'h0, ext_set_en = 1'h0;
  logic wake_req = 1'h0, windowed_watchdog_wake = 1'h0, a;
  logic [15:0] instr_word = 16'hFFFF, pm [3];
  logic [5:0] bank_select_reg = 6'h00;
  logic [7:0] f;
  logic [14:0] notes [$];
  wire [3:0] qphase;
  wire fill_we, fill_indexed, power_down_flag, timeout_flag, watchdog_clr;
  wire osc_stop;
  wire [13:0] fill_addr;
  wire [7:0] fill_data;
  wire [15:0] indirect_pointer0, indirect_pointer1, indirect_pointer2;
  integer seed = 16597, errors = 0, checks_done = 0, i, r, n;
  sspx_exec u_dut (.*);
  always #50 mclk = ~mclk;
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Words are only taken at Q4 while awake, so wait for that slot
  task issue(input logic [15:0] w);
    @(negedge mclk);
    for (n = 0; n < 20 && !(qphase === 4'h8 && osc_stop === 1'h0); n++)
      @(negedge mclk);
    instr_word = w;
    instr_valid = 1'h1;
  endtask
  always @(negedge mclk)
    if (fill_we === 1'h1)
      chk({fill_indexed, fill_addr, fill_data},
        {notes.pop_front(), 8'hFF});
  initial begin
    repeat (2) @(negedge mclk);
    rstn = 1'h1;
    for (r = 0; r < 4; r++) begin
      // Bank and mode change only after the last fill has landed
      @(negedge mclk);
      ext_set_en = 1'(r);
      bank_select_reg = 6'($random(seed));
      for (i = 0; i < 6; i++) begin
        a = 1'($random(seed));
        f = (i < 2) ? SSPX_IDX_MAX + i[7:0] : 8'($random(seed));
        issue({SSPX_FILL_OPC, a, f});
        notes.push_back({!a && ext_set_en && f <= SSPX_IDX_MAX,
          a ? {bank_select_reg, f} : {6'h00, f}});
      end
      issue(16'hFFFF);
    end
    pm = '{16'h0000, 16'h0000, 16'h0000};
    for (r = 0; r < 3; r++) begin
      for (i = 0; i < 4; i++) begin
        f = {i[1:0], r == 0 ? 6'h3F : 6'($random(seed))};
        issue({SSPX_PSUB_OPC, f});
        if (i < 3)
          pm[i] = pm[i] - f[5:0];
      end
      issue(16'hFFFF);
      issue(16'hFFFF);
      chk(indirect_pointer0, pm[0]);
      chk(indirect_pointer1, pm[1]);
      chk(indirect_pointer2, pm[2]);
    end
    chk({power_down_flag, timeout_flag}, 2'h3);
    for (r = 0; r < 2; r++) begin
      issue(SSPX_SLEEP_WORD);
      repeat (5) @(negedge mclk);
      instr_word = 16'hFFFF;
      chk({osc_stop, power_down_flag, timeout_flag}, 3'h5);
      chk(qphase, 4'h8);
      windowed_watchdog_wake = !r[0];
      wake_req = r[0];
      for (n = 0; n < 20 && osc_stop !== 1'h0; n++)
        @(negedge mclk);
      @(negedge mclk);
      windowed_watchdog_wake = 1'h0;
      wake_req = 1'h0;
      chk(timeout_flag, r[0]);
    end
    chk(notes.size(), 0);
    close_out();
  end
  initial begin
    #500000;
    errors++;
    close_out();
  end
endmodule
